// ===== hw/rceg_pkg.sv
package rceg_pkg;

  // clock rate and derived cycle counts
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  // write completion window, least time, round up
  localparam int unsigned WRITE_WIN_NS = 18_000;
  localparam int unsigned WRITE_WIN_CYC =
    (WRITE_WIN_NS + CLK_NS - 1) / CLK_NS;
  // glitch filter, longest time, round down
  localparam int unsigned GLITCH_NS = 3_000;
  localparam int unsigned GLITCH_CYC =
    (GLITCH_NS / CLK_NS < 1) ? 1 : GLITCH_NS / CLK_NS;
  // reset timeout, least time, round up
  localparam int unsigned RST_TIMEOUT_MS = 200;
  localparam longint unsigned RST_TIMEOUT_CYC =
    (longint'(RST_TIMEOUT_MS) * 1_000_000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 24;

  typedef enum logic [1:0] {
    RCEG_GATE_OFF = 2'b00,
    RCEG_GATE_ON = 2'b01,
    RCEG_GATE_HOLD = 2'b11
  } rceg_gate_t;

  typedef enum logic {
    RCEG_MODE_NORMAL = 1'b0,
    RCEG_MODE_BACKUP = 1'b1
  } rceg_mode_t;

  // supply comparator levels, already digitised
  typedef struct packed {
    logic belowTrip;
    logic belowBackup;
    logic aboveBackupHyst;
  } rceg_supply_t;

  typedef struct packed {
    rceg_supply_t sync1;
    rceg_supply_t sync2;
    logic ceSync1;
    logic ceSync2;
    logic [CNT_W-1:0] glitchCnt;
    logic [CNT_W-1:0] timeoutCnt;
    logic [CNT_W-1:0] winCnt;
    logic resetAct;
    rceg_gate_t gate;
    rceg_mode_t mode;
    logic ceOut;
    logic pullupEn;
    logic ceInOe;
  } rceg_state_t;

endpackage : rceg_pkg

// ===== hw/rceg_gate.sv
// Behaviour
// R1: while reset is asserted the select input is disabled and not passed on.
// R2: a write under way at reset keeps the gate on for 18 us, then it closes.
// R3: a select rising inside the 18 us window closes the gate at once.
// R4: once closed during power-down the gate stays closed if select falls.
// R5: on power-up the gate stays closed until reset releases after timeout.
// R6: with the gate closed the output is driven high from the higher supply.
// R7: with the gate open the internal pull-up is switched off.
// R8: backup mode only while main supply is below backup and trip levels.
// R9: switch to backup at the backup level, back at backup level plus 50 mV.
// R10: a dip of 3 us or less below the trip level issues no reset.
// R11: removing the backup supply above the trip level causes no reset.
// R12: reset holds at least the 200 ms timeout each time it asserts.
// R13: the timeout restarts whenever the supply falls below trip again.
// R14: with reset released the gate is open and passes every transition.
// R15: output equals select while open and is forced high while closed.
module rceg_gate #(
  parameter longint unsigned TIMEOUT_CYC = rceg_pkg::RST_TIMEOUT_CYC,
  parameter int unsigned WIN_CYC = rceg_pkg::WRITE_WIN_CYC,
  parameter int unsigned FILT_CYC = rceg_pkg::GLITCH_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // supply comparators and select input
  input wire rceg_pkg::rceg_supply_t supplyIn,
  input wire logic ceIn,
  // select output and pin controls
  output logic ceOut,
  output logic pullupEn,
  output logic ceInOe,
  output logic resetOut,
  output logic backupMode
);

  initial begin
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (64'h1 << rceg_pkg::CNT_W))
      $error("timeout count out of range");
    if (WIN_CYC < 1 || FILT_CYC < 1)
      $error("window and filter need one cycle");
    if (WIN_CYC >= 2 ** rceg_pkg::CNT_W - 1)
      $error("window count out of range");
    if (FILT_CYC >= 2 ** rceg_pkg::CNT_W - 1)
      $error("filter count out of range");
    if (TIMEOUT_CYC <= WIN_CYC)
      $error("timeout must outlast the write window");
  end

  localparam logic [rceg_pkg::CNT_W-1:0] TOUT =
    rceg_pkg::CNT_W'(TIMEOUT_CYC);
  localparam logic [rceg_pkg::CNT_W-1:0] WINL = rceg_pkg::CNT_W'(WIN_CYC);
  localparam logic [rceg_pkg::CNT_W-1:0] FILTL = rceg_pkg::CNT_W'(FILT_CYC);

  function automatic logic [rceg_pkg::CNT_W-1:0] satInc(
    input logic [rceg_pkg::CNT_W-1:0] v
  );
    satInc = (&v) ? v : v + 24'h000001;
  endfunction : satInc

  rceg_pkg::rceg_state_t stReg;
  rceg_pkg::rceg_state_t stNext;
  logic tripNow;
  logic ceRise;

  always_comb begin
    stNext = stReg;
    stNext.sync1 = supplyIn;
    stNext.sync2 = stReg.sync1;
    stNext.ceSync1 = ceIn;
    stNext.ceSync2 = stReg.ceSync1;
    // rise seen past the second flop only; ceOut lags ceSync2 by one
    // cycle while the gate is open, the only time the rise is used
    ceRise = stReg.ceSync2 & ~stReg.ceOut;
    // R10 glitch filter
    // short dips are absorbed; only the trip comparator is watched,
    // so a missing backup cell cannot start a reset (R11)
    if (stReg.sync2.belowTrip) begin
      stNext.glitchCnt = satInc(stReg.glitchCnt);
    end else begin
      stNext.glitchCnt = '0;
    end
    tripNow = stReg.sync2.belowTrip && (stReg.glitchCnt >= FILTL);
    // R12 R13 reset timeout
    if (tripNow) begin
      stNext.resetAct = 1'b1;
      stNext.timeoutCnt = '0;
    end else if (stReg.resetAct) begin
      if (stReg.timeoutCnt >= TOUT - 24'h000001) begin
        stNext.resetAct = 1'b0;
      end else begin
        stNext.timeoutCnt = satInc(stReg.timeoutCnt);
      end
    end
    // R8 R9 supply mode with hysteresis
    case (stReg.mode)
      rceg_pkg::RCEG_MODE_NORMAL: begin
        if (stReg.sync2.belowBackup && stReg.sync2.belowTrip)
          stNext.mode = rceg_pkg::RCEG_MODE_BACKUP;
      end
      default: begin
        if (stReg.sync2.aboveBackupHyst)
          stNext.mode = rceg_pkg::RCEG_MODE_NORMAL;
      end
    endcase
    // gate state machine
    case (stReg.gate)
      rceg_pkg::RCEG_GATE_ON: begin
        stNext.winCnt = '0;
        if (stNext.resetAct) begin
          // R2 write under way holds gate
          if (!stReg.ceSync2) begin
            stNext.gate = rceg_pkg::RCEG_GATE_HOLD;
          end else begin
            stNext.gate = rceg_pkg::RCEG_GATE_OFF;
          end
        end
      end
      rceg_pkg::RCEG_GATE_HOLD: begin
        stNext.winCnt = satInc(stReg.winCnt);
        // R3 early close on rise
        if (ceRise) begin
          stNext.gate = rceg_pkg::RCEG_GATE_OFF;
        // R2 window expiry
        end else if (stReg.winCnt >= WINL - 24'h000001) begin
          stNext.gate = rceg_pkg::RCEG_GATE_OFF;
        end
      end
      default: begin
        // R4 R5 stays closed until release
        stNext.winCnt = '0;
        if (!stNext.resetAct)
          stNext.gate = rceg_pkg::RCEG_GATE_ON;
      end
    endcase
    // R1 R6 R7 R14 R15 output drive
    if (stNext.gate == rceg_pkg::RCEG_GATE_OFF) begin
      stNext.ceOut = 1'b1;
      stNext.pullupEn = 1'b1;
      stNext.ceInOe = 1'b0;
    end else begin
      stNext.ceOut = stReg.ceSync2;
      stNext.pullupEn = 1'b0;
      stNext.ceInOe = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stReg <= '{
        sync1: 3'h0, sync2: 3'h0, ceSync1: 1'b1, ceSync2: 1'b1,
        glitchCnt: 24'h000000, timeoutCnt: 24'h000000,
        winCnt: 24'h000000, resetAct: 1'b1,
        gate: rceg_pkg::RCEG_GATE_OFF, mode: rceg_pkg::RCEG_MODE_NORMAL,
        ceOut: 1'b1, pullupEn: 1'b1, ceInOe: 1'b0};
    end else begin
      stReg <= stNext;
    end
  end

  assign ceOut = stReg.ceOut;
  assign pullupEn = stReg.pullupEn;
  assign ceInOe = stReg.ceInOe;
  assign resetOut = stReg.resetAct;
  assign backupMode = stReg.mode;

  sequence s_closed;
    ceOut && pullupEn && !ceInOe;
  endsequence

  property p_reset_closes;
    @(posedge core_clk) disable iff (!rst_n)
    (resetOut && stReg.gate != rceg_pkg::RCEG_GATE_HOLD) |-> s_closed;
  endproperty
  a_reset_closes: assert property (p_reset_closes) // R1
    else $error("gate open while reset closed it");

  property p_window_bound;
    @(posedge core_clk) disable iff (!rst_n)
    stReg.gate == rceg_pkg::RCEG_GATE_HOLD |->
      stReg.winCnt < WINL;
  endproperty
  a_window_bound: assert property (p_window_bound) // R2
    else $error("write window overran");

  property p_rise_closes;
    @(posedge core_clk) disable iff (!rst_n)
    (stReg.gate == rceg_pkg::RCEG_GATE_HOLD && ceRise) |=> s_closed;
  endproperty
  a_rise_closes: assert property (p_rise_closes) // R3
    else $error("select rise did not close gate");

  property p_stay_closed;
    @(posedge core_clk) disable iff (!rst_n)
    (stReg.gate == rceg_pkg::RCEG_GATE_OFF && resetOut)
      |=> !resetOut || stReg.gate == rceg_pkg::RCEG_GATE_OFF;
  endproperty
  a_stay_closed: assert property (p_stay_closed) // R4
    else $error("gate reopened during reset");

  property p_open_needs_release;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(ceInOe) |-> !resetOut;
  endproperty
  a_open_needs_release: assert property (p_open_needs_release) // R5
    else $error("gate opened with reset held");

  property p_pullup_off;
    @(posedge core_clk) disable iff (!rst_n)
    ceInOe |-> !pullupEn;
  endproperty
  a_pullup_off: assert property (p_pullup_off) // R7
    else $error("pull-up on with gate open");

  property p_backup_entry;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(backupMode) |->
      $past(stReg.sync2.belowBackup) && $past(stReg.sync2.belowTrip);
  endproperty
  a_backup_entry: assert property (p_backup_entry) // R8
    else $error("backup entered without both conditions");

  property p_backup_exit;
    @(posedge core_clk) disable iff (!rst_n)
    $fell(backupMode) |-> $past(stReg.sync2.aboveBackupHyst);
  endproperty
  a_backup_exit: assert property (p_backup_exit) // R9
    else $error("backup left without hysteresis margin");

  property p_no_short_reset;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(resetOut) |->
      $past(stReg.sync2.belowTrip) && $past(stReg.glitchCnt) >= FILTL;
  endproperty
  a_no_short_reset: assert property (p_no_short_reset) // R10
    else $error("reset from a short dip");

  property p_hold_timeout;
    @(posedge core_clk) disable iff (!rst_n)
    $fell(resetOut) |-> $past(stReg.timeoutCnt) >= TOUT - 24'h000001;
  endproperty
  a_hold_timeout: assert property (p_hold_timeout) // R12
    else $error("reset released before timeout");

  property p_restart;
    @(posedge core_clk) disable iff (!rst_n)
    tripNow |=> resetOut && stReg.timeoutCnt == '0;
  endproperty
  a_restart: assert property (p_restart) // R13
    else $error("timeout not restarted");

  property p_pass;
    @(posedge core_clk) disable iff (!rst_n)
    ceInOe |-> ceOut == $past(ceIn, 3);
  endproperty
  a_pass: assert property (p_pass) // R14 R15
    else $error("open gate does not follow select");

  sequence s_open;
    ceInOe && !pullupEn;
  endsequence

  // write window split into its running and its last cycle
  sequence s_hold_early;
    stReg.gate == rceg_pkg::RCEG_GATE_HOLD && !ceRise &&
      stReg.winCnt < WINL - 24'h000001;
  endsequence

  sequence s_hold_last;
    stReg.gate == rceg_pkg::RCEG_GATE_HOLD && !ceRise &&
      stReg.winCnt == WINL - 24'h000001;
  endsequence

  property p_closed_high;
    @(posedge core_clk) disable iff (!rst_n)
    !ceInOe |-> ceOut && pullupEn;
  endproperty
  a_closed_high: assert property (p_closed_high) // R6
    else $error("closed gate does not drive output high");

  property p_hold_stays;
    @(posedge core_clk) disable iff (!rst_n)
    s_hold_early |=> s_open;
  endproperty
  a_hold_stays: assert property (p_hold_stays) // R2
    else $error("gate closed before the write window ran out");

  property p_window_close;
    @(posedge core_clk) disable iff (!rst_n)
    s_hold_last |=> s_closed;
  endproperty
  a_window_close: assert property (p_window_close) // R2
    else $error("gate still open after the write window");

  property p_open_when_run;
    @(posedge core_clk) disable iff (!rst_n)
    !resetOut |-> s_open;
  endproperty
  a_open_when_run: assert property (p_open_when_run) // R14
    else $error("gate closed with reset released");

  // reset has one cause only, so a pulled backup cell cannot start it
  property p_reset_only_trip;
    @(posedge core_clk) disable iff (!rst_n)
    (!resetOut && !tripNow) |=> !resetOut;
  endproperty
  a_reset_only_trip: assert property (p_reset_only_trip) // R11
    else $error("reset without a filtered trip");

  property p_backup_switch;
    @(posedge core_clk) disable iff (!rst_n)
    (!backupMode && stReg.sync2.belowBackup && stReg.sync2.belowTrip)
      |=> backupMode;
  endproperty
  a_backup_switch: assert property (p_backup_switch) // R9
    else $error("no switch to backup below both levels");

endmodule : rceg_gate

// ===== verification/rceg_host.sv
module rceg_host (
  // clock
  input wire logic core_clk,
  // write request from bench
  input wire logic go,
  input wire logic [7:0] len,
  // select to the gate, active low
  output logic ceIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  initial begin
    ceIn = 1'b1;
    cnt = 8'h00;
  end
  // select held low for len cycles, then released high
  always @(posedge core_clk) begin
    if (go) begin
      ceIn <= 1'b0;
      cnt <= len;
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 8'h01;
    end else begin
      cnt <= 8'h00;
      ceIn <= 1'b1;
    end
  end
endmodule : rceg_host

// ===== verification/rceg_gate_tb.sv
module rceg_gate_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 50;
  localparam int WIN = 40;
  localparam int FILT = 4;
  logic core_clk;
  logic rst_n;
  logic go;
  logic [7:0] len;
  logic ceIn, ceOut, pullupEn, ceInOe, resetOut, backupMode;
  rceg_pkg::rceg_supply_t supplyIn;
  int miscompares = 0, n_tests = 0, seed = 95, cyc = 0, n, c;
  logic expQ[$];
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  rceg_gate #(.TIMEOUT_CYC(TMO), .WIN_CYC(WIN), .FILT_CYC(FILT)) dut (
    .core_clk, .rst_n, .supplyIn, .ceIn, .ceOut, .pullupEn, .ceInOe,
    .resetOut, .backupMode);
  rceg_host host (.core_clk, .go, .len, .ceIn);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task cw(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cw
  task write(input int l);
    @(posedge core_clk);
    len <= 8'(l);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask : write
  task trip(input logic v);
    @(posedge core_clk);
    supplyIn.belowTrip <= v;
  endtask : trip
  task waitRst(input logic v, output int k);
    k = 0;
    while (resetOut !== v && k < 300) begin
      @(negedge core_clk);
      k++;
    end
  endtask : waitRst
  task waitOut(output int k);
    k = 0;
    while (ceOut !== 1'b1 && k < 100) begin
      @(negedge core_clk);
      k++;
    end
  endtask : waitOut
  // every change of the gated select must have been predicted
  always @(ceOut)
    if (rst_n) chk(ceOut, expQ.size() ? expQ.pop_front() : !ceOut);
  always @(negedge core_clk) if (rst_n) chk(pullupEn, !ceInOe);
  always @(negedge core_clk) if (rst_n && !ceInOe) chk(ceOut, 1'b1);
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      end_sim;
    end
  end
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    len = 8'h01;
    supplyIn = '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    fork
      write(3);
      waitRst(1'b0, n);
    join
    chk(n >= TMO, 1);
    $display("test power_up done");
    for (int i = 0; i < 8; i++) begin
      n = 1 + $unsigned($random(seed)) % 8;
      expQ.push_back(1'b0);
      expQ.push_back(1'b1);
      write(n);
      cw(n + 6);
    end
    chk(expQ.size(), 0);
    $display("test normal done");
    trip(1'b1);
    cw(FILT);
    trip(1'b0);
    cw(FILT + 6);
    chk(resetOut, 0);
    @(posedge core_clk);
    supplyIn.belowBackup <= 1'b1;
    cw(6);
    chk(backupMode, 0);
    $display("test glitch done");
    expQ.push_back(1'b0);
    expQ.push_back(1'b1);
    write(100);
    cw(3);
    trip(1'b1);
    waitRst(1'b1, n);
    waitOut(c);
    chk(c, WIN);
    chk(ceIn, 0);
    chk(backupMode, 1);
    cw(100);
    write(5);
    cw(10);
    chk(ceInOe, 0);
    chk(pullupEn, 1);
    $display("test window done");
    @(posedge core_clk);
    supplyIn.belowBackup <= 1'b0;
    cw(6);
    chk(backupMode, 1);
    @(posedge core_clk);
    supplyIn.aboveBackupHyst <= 1'b1;
    cw(6);
    chk(backupMode, 0);
    trip(1'b0);
    cw(TMO / 2);
    trip(1'b1);
    cw(FILT + 4);
    trip(1'b0);
    waitRst(1'b0, n);
    chk(n >= TMO, 1);
    $display("test restart done");
    cw(5);
    expQ.push_back(1'b0);
    expQ.push_back(1'b1);
    write(30);
    cw(3);
    trip(1'b1);
    waitRst(1'b1, n);
    waitOut(c);
    chk(c < WIN - 5, 1);
    chk(ceIn, 1);
    chk(ceInOe, 0);
    trip(1'b0);
    waitRst(1'b0, n);
    chk(expQ.size(), 0);
    $display("test early_close done");
    end_sim;
  end
endmodule : rceg_gate_tb
